/* File: design/ubg_map.vh */
// register map, field positions and timing constants for the baud generator
`ifndef UBG_MAP_VH
`define UBG_MAP_VH
`define UBG_ADDR_BAUD_CTRL 4'h0
`define UBG_ADDR_MODE 4'h1
`define UBG_ADDR_STATUS 4'h2
`define UBG_BAUD_RST 8'h00
`define UBG_MODE_RST 8'h00
`define UBG_SEL_HI 7
`define UBG_SEL_LO 6
`define UBG_DIV_HI 4
`define UBG_DIV_LO 0
`define UBG_PWR_BIT 7
`define UBG_TXE_BIT 6
`define UBG_RXE_BIT 5
`define UBG_DIV_MIN 5'h08
`define UBG_TAP0_RATIO 8'h01
`define UBG_TAP1_RATIO 8'h02
`define UBG_TAP2_RATIO 8'h04
`define UBG_TAP3_RATIO 8'h08
`define UBG_FRAME_BITS 4'ha
`define UBG_ZERO5 5'h00
`define UBG_ONE5 5'h01
`endif

/* File: design/ubg_prescaler.v */
// prescaler: four divide taps, one selected, output as a one-cycle enable
`timescale 1ns/100ps
`include "ubg_map.vh"
module ubg_prescaler (
   input wire i_clk_sys,
   input wire i_rst_n,
   input wire i_run,
   input wire [1:0] i_sel,
   output reg o_tick
);
   reg [7:0] cnt_reg;
   reg [7:0] ratio;
   always @* begin
      case (i_sel)
         2'h0: ratio = `UBG_TAP0_RATIO;
         2'h1: ratio = `UBG_TAP1_RATIO;
         2'h2: ratio = `UBG_TAP2_RATIO;
         default: ratio = `UBG_TAP3_RATIO;
      endcase
   end
   always @(posedge i_clk_sys) begin
      if (!i_rst_n || !i_run) begin
         cnt_reg <= 8'h00;
         o_tick <= 1'b0;
      end else if (cnt_reg >= ratio - 8'h01) begin
         cnt_reg <= 8'h00;
         o_tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
         o_tick <= 1'b0;
      end
   end
endmodule

/* File: design/ubg_baud_gen.v */
// baud generator with two divider counters and receive match filter
// What this block does
// - rx pin sampled, changes on two equal samples
// - internal rx lags pin by two base clocks
// - two independent 5-bit counters, tx and rx
// - base clock from select bits, only when powered
// - tx counter held zero unless power and tx enable
// - tx counter runs when power and tx enable
// - tx counter cleared on first transmit byte write
// - rx counter held zero unless power and rx enable
// - rx counter runs start bit to frame end
// - divisor field bits 4:0, valid 8 to 31
// - bit rate is base clock over 2k
// - rx latch points timed by rx counter
// - latch timing margin of k-2 base clocks each side
// - falling edge, count k, low confirms start
`timescale 1ns/100ps
`include "ubg_map.vh"
module ubg_baud_gen (
   input wire i_clk_sys,
   input wire i_rst_n,
   input wire [3:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   input wire i_serial_rx_pin,
   input wire i_tx_write,
   output reg o_tx_bit_tick,
   output reg o_rx_sample_tick,
   output reg o_rx_start_ok,
   output reg o_rx_data,
   output reg o_rx_busy,
   output reg o_base_clk_en
);
   localparam ST_IDLE = 2'h0;
   localparam ST_START = 2'h1;
   localparam ST_FRAME = 2'h2;

   reg [7:0] baud_generator_control_reg;
   reg [7:0] serial_mode_register_reg;
   reg [1:0] pin_sync_reg;
   reg smp_reg;
   reg filt_reg;
   reg filt_d_reg;
   reg [4:0] tx_cnt_reg;
   reg [4:0] rx_cnt_reg;
   reg [1:0] rx_state_reg;
   reg [3:0] rx_bits_reg;
   reg rx_half_reg;
   reg tx_half_reg;
   reg tx_first_reg;
   wire base_tick;
   wire pwr;
   wire tx_run;
   wire rx_run;
   wire [4:0] k;

   // wraps a count at the divisor
   function [4:0] div_step;
      input [4:0] cnt;
      input [4:0] kv;
      begin
         if (cnt >= kv - `UBG_ONE5)
            div_step = `UBG_ZERO5;
         else
            div_step = cnt + `UBG_ONE5;
      end
   endfunction

   assign pwr = serial_mode_register_reg[`UBG_PWR_BIT];
   assign tx_run = pwr & serial_mode_register_reg[`UBG_TXE_BIT];
   assign rx_run = pwr & serial_mode_register_reg[`UBG_RXE_BIT];
   assign k = baud_generator_control_reg[`UBG_DIV_HI:`UBG_DIV_LO];

   ubg_prescaler u_pre (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_run(pwr),
      .i_sel(baud_generator_control_reg[`UBG_SEL_HI:`UBG_SEL_LO]),
      .o_tick(base_tick)
   );

   // register port, read data one cycle later
   always @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         baud_generator_control_reg <= `UBG_BAUD_RST;
         serial_mode_register_reg <= `UBG_MODE_RST;
         o_rdata <= 8'h00;
      end else begin
         if (i_wr && i_addr == `UBG_ADDR_BAUD_CTRL)
            baud_generator_control_reg <= i_wdata;
         if (i_wr && i_addr == `UBG_ADDR_MODE)
            serial_mode_register_reg <= {i_wdata[7:5], 5'h00};
         if (i_rd) begin
            case (i_addr)
               `UBG_ADDR_BAUD_CTRL: o_rdata <= baud_generator_control_reg;
               `UBG_ADDR_MODE: o_rdata <= serial_mode_register_reg;
               `UBG_ADDR_STATUS: o_rdata <= {5'h00, rx_state_reg, filt_reg};
               default: o_rdata <= 8'h00;
            endcase
         end else begin
            o_rdata <= 8'h00;
         end
      end
   end

   // pin synchroniser, then two-sample match filter on base clock
   always @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         pin_sync_reg <= 2'h3;
         smp_reg <= 1'b1;
         filt_reg <= 1'b1;
         filt_d_reg <= 1'b1;
      end else begin
         pin_sync_reg <= {pin_sync_reg[0], i_serial_rx_pin};
         if (base_tick && rx_run) begin
            smp_reg <= pin_sync_reg[1];
            if (smp_reg == pin_sync_reg[1])
               filt_reg <= pin_sync_reg[1];
            filt_d_reg <= filt_reg;
         end
      end
   end

   // transmit counter
   always @(posedge i_clk_sys) begin
      if (!i_rst_n || !tx_run) begin
         tx_cnt_reg <= `UBG_ZERO5;
         tx_half_reg <= 1'b0;
         tx_first_reg <= 1'b1;
         o_tx_bit_tick <= 1'b0;
      end else if (i_tx_write && tx_first_reg) begin
         tx_cnt_reg <= `UBG_ZERO5;
         tx_half_reg <= 1'b0;
         tx_first_reg <= 1'b0;
         o_tx_bit_tick <= 1'b0;
      end else if (base_tick) begin
         tx_cnt_reg <= div_step(tx_cnt_reg, k);
         if (tx_cnt_reg >= k - `UBG_ONE5)
            tx_half_reg <= ~tx_half_reg;
         o_tx_bit_tick <= (tx_cnt_reg >= k - `UBG_ONE5) & tx_half_reg;
      end else begin
         o_tx_bit_tick <= 1'b0;
      end
   end

   // receive counter: start detect, then 2k-per-bit latch points
   always @(posedge i_clk_sys) begin
      if (!i_rst_n || !rx_run) begin
         rx_cnt_reg <= `UBG_ZERO5;
         rx_state_reg <= ST_IDLE;
         rx_bits_reg <= 4'h0;
         rx_half_reg <= 1'b0;
         o_rx_sample_tick <= 1'b0;
         o_rx_start_ok <= 1'b0;
      end else begin
         o_rx_sample_tick <= 1'b0;
         o_rx_start_ok <= 1'b0;
         if (base_tick) begin
            case (rx_state_reg)
               ST_IDLE: begin
                  rx_cnt_reg <= `UBG_ZERO5;
                  if (filt_d_reg && !filt_reg)
                     rx_state_reg <= ST_START;
               end
               ST_START: begin
                  rx_cnt_reg <= div_step(rx_cnt_reg, k);
                  if (rx_cnt_reg >= k - `UBG_ONE5) begin
                     if (!filt_reg) begin
                        rx_state_reg <= ST_FRAME;
                        o_rx_start_ok <= 1'b1;
                        rx_bits_reg <= 4'h0;
                        rx_half_reg <= 1'b0;
                     end else begin
                        rx_state_reg <= ST_IDLE;
                     end
                  end
               end
               ST_FRAME: begin
                  rx_cnt_reg <= div_step(rx_cnt_reg, k);
                  if (rx_cnt_reg >= k - `UBG_ONE5) begin
                     rx_half_reg <= ~rx_half_reg;
                     if (rx_half_reg) begin
                        // latch point mid-bit, k-2 clocks of margin each side
                        o_rx_sample_tick <= 1'b1;
                        rx_bits_reg <= rx_bits_reg + 4'h1;
                        if (rx_bits_reg == `UBG_FRAME_BITS - 4'h1) begin
                           rx_state_reg <= ST_IDLE;
                           rx_cnt_reg <= `UBG_ZERO5;
                        end
                     end
                  end
               end
               default: rx_state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   always @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_rx_data <= 1'b1;
         o_rx_busy <= 1'b0;
         o_base_clk_en <= 1'b0;
      end else begin
         o_rx_data <= filt_reg;
         o_rx_busy <= (rx_state_reg != ST_IDLE);
         o_base_clk_en <= base_tick & pwr;
      end
   end
endmodule

/* File: test/ubg_chk.sv */
// port assertions for the baud generator
`timescale 1ns/100ps
`include "ubg_map.vh"
module ubg_chk (
   input wire i_clk_sys,
   input wire i_rst_n,
   input wire [3:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] o_rdata,
   input wire o_tx_bit_tick,
   input wire o_rx_start_ok,
   input wire o_rx_data,
   input wire o_rx_busy,
   input wire o_base_clk_en
);
   reg [7:0] baud_reg;
   reg [2:0] mode_reg;
   always @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         baud_reg <= 8'h00;
         mode_reg <= 3'h0;
      end else if (i_wr && i_addr == `UBG_ADDR_BAUD_CTRL) begin
         baud_reg <= i_wdata;
      end else if (i_wr && i_addr == `UBG_ADDR_MODE) begin
         mode_reg <= i_wdata[7:5];
      end
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   sequence s_pwr_off; (!mode_reg[2])[*3]; endsequence
   sequence s_tx_off; (mode_reg[2:1] != 2'h3)[*3]; endsequence
   sequence s_rx_off; (!(mode_reg[2] && mode_reg[0]))[*3]; endsequence
   chk_base_gated: assert property (s_pwr_off |-> !o_base_clk_en)
      else $error("base clock while unpowered");
   chk_tx_halted: assert property (s_tx_off |-> !o_tx_bit_tick)
      else $error("tx tick while disabled");
   chk_rx_halted: assert property (s_rx_off |-> !o_rx_busy)
      else $error("rx busy while disabled");
   chk_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside read slot");
   chk_baud_read: assert property (i_rd && i_addr == 4'h0 |=> o_rdata == $past(baud_reg))
      else $error("baud control readback");
   chk_unmapped_read: assert property (i_rd && i_addr > 4'h2 |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_start_low: assert property (o_rx_start_ok |-> !o_rx_data)
      else $error("start confirmed on high line");
   chk_tick_space: assert property (o_tx_bit_tick |=> (!o_tx_bit_tick)[*8])
      else $error("tx ticks too close");
endmodule
bind ubg_baud_gen ubg_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_tx_bit_tick(o_tx_bit_tick), .o_rx_start_ok(o_rx_start_ok), .o_rx_data(o_rx_data),
   .o_rx_busy(o_rx_busy), .o_base_clk_en(o_base_clk_en));

/* File: test/ubg_remote.sv */
// remote transmitter model driving the receive pin
`timescale 1ns/100ps
module ubg_remote (
   input wire i_clk_sys,
   output reg o_line
);
   initial o_line = 1'b1;
   // start, eight data bits lsb first, stop; line idles high
   task send(input [7:0] data, input int cyc);
      reg [9:0] f;
      f = {1'b1, data, 1'b0};
      for (int i = 0; i < 10; i++) begin
         o_line <= f[i];
         repeat (cyc) @(posedge i_clk_sys);
      end
   endtask
   task glitch();
      o_line <= 1'b0;
      @(posedge i_clk_sys);
      o_line <= 1'b1;
   endtask
endmodule

/* File: test/ubg_baud_gen_test.sv */
// self-checking bench for the baud generator
`timescale 1ns/100ps
`include "ubg_map.vh"
module ubg_baud_gen_test;
   reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, tx_wr = 1'b0;
   reg [3:0] addr = 4'h0;
   reg [7:0] wdata = 8'h00;
   wire [7:0] rdata;
   wire line, tick, samp, start_ok, rx_data, busy, base_en;
   int error_cnt = 0, n_compared = 0, n, s, st;
   // address, write value, expected readback
   reg [19:0] rows [0:3] = '{20'h0c8c8, 20'h1ffe0, 20'h35500, 20'h01f1f};
   initial forever #2 clk = ~clk;
   ubg_remote rem (.i_clk_sys(clk), .o_line(line));
   ubg_baud_gen dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_serial_rx_pin(line), .i_tx_write(tx_wr),
      .o_tx_bit_tick(tick), .o_rx_sample_tick(samp), .o_rx_start_ok(start_ok),
      .o_rx_data(rx_data), .o_rx_busy(busy), .o_base_clk_en(base_en));
   task check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wreg(input [3:0] a, input [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rreg(input [3:0] a, input [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, exp);
   endtask
   task gap(output int c);
      repeat (2) begin
         c = 0;
         do begin
            @(negedge clk);
            c++;
         end while (tick !== 1'b1 && c < 600);
      end
   endtask
   task watch(input int len);
      s = 0;
      st = 0;
      repeat (len) begin
         @(negedge clk);
         s += (samp === 1'b1) + (tick !== 1'b0) + (base_en !== 1'b0);
         st += (start_ok === 1'b1);
      end
   endtask
   task conclude();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         wreg(rows[i][19:16], rows[i][15:8]);
         rreg(rows[i][19:16], rows[i][7:0]);
      end
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rreg(`UBG_ADDR_BAUD_CTRL, `UBG_BAUD_RST);
      rreg(`UBG_ADDR_MODE, `UBG_MODE_RST);
      $display("registers done");
      wreg(`UBG_ADDR_MODE, 8'hc0);
      for (int k = 0; k < 5; k++) begin
         wreg(`UBG_ADDR_BAUD_CTRL, (k < 4) ? {k[1:0], 6'h08} : 8'h1f);
         gap(n);
         gap(n);
         check(n, (k < 4) ? (16 << k) : 62);
      end
      $display("tx rates done");
      wreg(`UBG_ADDR_BAUD_CTRL, 8'h08);
      wreg(`UBG_ADDR_MODE, 8'h60);
      repeat (4) @(posedge clk);
      watch(200);
      check(s, 0);
      for (int m = 0; m < 2; m++) begin
         wreg(`UBG_ADDR_MODE, m ? 8'ha0 : 8'h80);
         rem.glitch();
         watch(60);
         check(st, 0);
         fork
            rem.send(8'h55, 16);
            watch(220);
         join
         check(st, m);
         check(s, m ? 230 : 220);
         check({busy, rx_data}, 2'h1);
      end
      $display("rx done");
      // first byte write restarts the tx divider: next tick 2k base ticks later
      wreg(`UBG_ADDR_MODE, 8'hc0);
      repeat (8) @(posedge clk);
      tx_wr <= 1'b1;
      @(posedge clk);
      tx_wr <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (tick !== 1'b1 && n < 600);
      check(n, 17);
      $display("tx restart done");
      conclude();
   end
endmodule
